/* File: p2pl_defines.svh */
// Constants and function list for the port 2 pin function logic.
// Function
// R1: Bits 0 and 1 use the digital path only while segment select is low.
// R2: Segment select is high when LCD memory extent is at least 0E0h.
// R3: Bits 2 to 5 use the digital path only while analog disconnect is low.
// R4: Bit 3 analog disconnect asserts when supervisor level equals 1111b; others tied off.
// R5: Select 0 takes direction and data from registers; select 1 from the module. Bits 0 and 3 keep register direction under select 1.
// R6: Bit 0 peripheral drives timer channel 2 output and feeds capture input A.
// R7: Bit 1 peripheral carries the serial clock with module-controlled direction.
// R8: Bit 2 peripheral is input only, feeding serial slave transmit enable.
// R9: Bit 4 peripheral is output only, driving asynchronous transmit data.
// R10: Bit 5 peripheral is input only, feeding asynchronous receive data.
// R11: Bits 6 and 7 have registers but no pad; module output low.
// R12: Flags of bits 6 and 7 change only by software writes.
// R13: Bonded pins set flags on the selected edge; request when flag and enable.
// R14: Input register shows the synchronized pad level for bonded bits.
`ifndef P2PL_DEFINES_SVH
`define P2PL_DEFINES_SVH
// ----------------------------------------
// Register map, offsets in 32-bit words
// ----------------------------------------
`define P2PL_OFS_IN 4'h0
`define P2PL_OFS_OUT 4'h1
`define P2PL_OFS_DIR 4'h2
`define P2PL_OFS_IFG 4'h3
`define P2PL_OFS_IES 4'h4
`define P2PL_OFS_IE 4'h5
`define P2PL_OFS_SEL 4'h6
`define P2PL_OFS_EVT 4'h7
`define P2PL_OFS_MSK 4'h8
// ----------------------------------------
// Values
// ----------------------------------------
`define P2PL_RST8 8'h00
`define P2PL_LCD_LIMIT 8'he0
`define P2PL_SVS_EXT 4'hf
`define P2PL_BONDED 8'h3f
`define P2PL_EVT_W 2
`endif

/* File: p2pl_pkg.sv */
// Types shared by the port 2 pin function logic.
package p2pl_pkg;
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } p2pl_pad_s;
    typedef enum logic [1:0] {
        P2PL_IDLE = 2'b01,
        P2PL_ACK = 2'b10
    } p2pl_bus_e;
endpackage

/* File: p2pl_top.sv */
// Port 2 pin logic with Avalon-MM register slave and interrupt.
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`include "p2pl_defines.svh"
module p2pl_top (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [5:0] PAD_IN,
    output logic [5:0] PAD_OUT,
    output logic [5:0] PAD_OE,
    input wire logic [7:0] LCD_MEMORY_EXTENT,
    input wire logic [3:0] SUPERVISOR_LEVEL_FIELD,
    output logic PORT_OR_SEGMENT_SELECT,
    output logic SUPERVISOR_EXT_INPUT_EN,
    input wire logic TIMER_CH2_OUT_SIGNAL,
    output logic TIMER_CH2_CAPTURE_IN_A,
    input wire logic SERIAL_CLOCK_DIR_FROM_MODULE,
    input wire logic SERIAL_UNIT_CLOCK_OUT,
    output logic SERIAL_UNIT_CLOCK_IN,
    output logic SERIAL_SLAVE_TX_ENABLE,
    input wire logic ASYNC_TX_DATA,
    output logic ASYNC_RX_DATA,
    output logic PIN_IRQ_REQUEST,
    output logic IRQ
);
    logic [7:0] pin_input_bits_r, pin_output_bits_r, pin_direction_bits_r;
    logic [7:0] pin_irq_flag_bits_r, pin_edge_select_bits_r, pin_irq_enable_bits_r;
    logic [7:0] pin_function_select_r;
    logic [7:0] prev_in_r;
    logic [1:0] evt_r, msk_r;
    logic [7:0] mod_out, mod_dir, dig_en, edge_hit;
    logic [5:0] pad_q1_r;
    logic [7:0] pad_s;
    logic [31:0] rdata_nxt;
    logic wr, flag_wr, req_prev_r, seg_prev_r;
    p2pl_pkg::p2pl_bus_e bus_r;
    p2pl_pkg::p2pl_pad_s pad_nxt, pad_r;

    // ----------------------------------------
    // Pin routing
    // ----------------------------------------
    always_comb begin
        // R2: extent compare drives segment select.
        PORT_OR_SEGMENT_SELECT = (LCD_MEMORY_EXTENT >= `P2PL_LCD_LIMIT);
        // R4: supervisor external input on bit 3.
        SUPERVISOR_EXT_INPUT_EN = (SUPERVISOR_LEVEL_FIELD == `P2PL_SVS_EXT);
        // R1: segment use blocks bits 0 and 1.
        dig_en = 8'hff;
        dig_en[0] = !PORT_OR_SEGMENT_SELECT;
        dig_en[1] = !PORT_OR_SEGMENT_SELECT;
        // R3: analog disconnect blocks bit 3.
        dig_en[3] = !SUPERVISOR_EXT_INPUT_EN;
        // R6: timer channel 2 on bit 0.
        mod_out = 8'h00;
        mod_dir = pin_direction_bits_r;
        mod_out[0] = TIMER_CH2_OUT_SIGNAL;
        // R7: bidirectional serial clock on bit 1.
        mod_out[1] = SERIAL_UNIT_CLOCK_OUT;
        mod_dir[1] = SERIAL_CLOCK_DIR_FROM_MODULE;
        // R8: transmit enable pin is input.
        mod_dir[2] = 1'b0;
        // R9: transmit data pin is output.
        mod_dir[4] = 1'b1;
        mod_out[4] = ASYNC_TX_DATA;
        // R10: receive data pin is input.
        mod_dir[5] = 1'b0;
        // R5: select chooses register or module control.
        pad_nxt.out = pin_function_select_r & mod_out | ~pin_function_select_r & pin_output_bits_r;
        pad_nxt.oe = pin_function_select_r & mod_dir;
        pad_nxt.oe = (pad_nxt.oe | ~pin_function_select_r & pin_direction_bits_r) & dig_en;
    end

    // Pad drive is registered so data outputs come from flip-flops.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            pad_r <= '0;
        end else begin
            pad_r <= pad_nxt;
        end
    end
    // R11: bits 6 and 7 reach no pad.
    assign PAD_OUT = pad_r.out[5:0];
    assign PAD_OE = pad_r.oe[5:0];

    // ----------------------------------------
    // Input synchronizer and module inputs
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            pad_q1_r <= '0;
            pin_input_bits_r <= `P2PL_RST8;
        end else begin
            pad_q1_r <= PAD_IN;
            // R14: input register follows the pad.
            pin_input_bits_r <= {2'b00, pad_q1_r};
        end
    end
    assign pad_s = pin_input_bits_r & {8{1'b1}} & `P2PL_BONDED & dig_en;
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            TIMER_CH2_CAPTURE_IN_A <= 1'b0;
            SERIAL_UNIT_CLOCK_IN <= 1'b0;
            SERIAL_SLAVE_TX_ENABLE <= 1'b0;
            ASYNC_RX_DATA <= 1'b0;
        end else begin
            TIMER_CH2_CAPTURE_IN_A <= pad_s[0];
            SERIAL_UNIT_CLOCK_IN <= pad_s[1];
            SERIAL_SLAVE_TX_ENABLE <= pad_s[2];
            ASYNC_RX_DATA <= pad_s[5];
        end
    end

    // ----------------------------------------
    // Avalon-MM slave
    // ----------------------------------------
    // One wait cycle lets read data be registered before it is taken.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            bus_r <= p2pl_pkg::P2PL_IDLE;
        end else begin
            unique case (bus_r)
                p2pl_pkg::P2PL_IDLE: begin
                    if (AVS_READ || AVS_WRITE) begin
                        bus_r <= p2pl_pkg::P2PL_ACK;
                    end
                end
                p2pl_pkg::P2PL_ACK: begin
                    bus_r <= p2pl_pkg::P2PL_IDLE;
                end
                default: begin
                    bus_r <= p2pl_pkg::P2PL_IDLE;
                end
            endcase
        end
    end
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && bus_r != p2pl_pkg::P2PL_ACK;
    assign wr = AVS_WRITE && bus_r == p2pl_pkg::P2PL_ACK && AVS_BYTEENABLE[0];
    assign flag_wr = wr && AVS_ADDRESS == `P2PL_OFS_IFG;

    always_comb begin
        rdata_nxt = '0;
        unique case (AVS_ADDRESS)
            `P2PL_OFS_IN: rdata_nxt[7:0] = pin_input_bits_r;
            `P2PL_OFS_OUT: rdata_nxt[7:0] = pin_output_bits_r;
            `P2PL_OFS_DIR: rdata_nxt[7:0] = pin_direction_bits_r;
            `P2PL_OFS_IFG: rdata_nxt[7:0] = pin_irq_flag_bits_r;
            `P2PL_OFS_IES: rdata_nxt[7:0] = pin_edge_select_bits_r;
            `P2PL_OFS_IE: rdata_nxt[7:0] = pin_irq_enable_bits_r;
            `P2PL_OFS_SEL: rdata_nxt[7:0] = pin_function_select_r;
            `P2PL_OFS_EVT: rdata_nxt[1:0] = evt_r;
            `P2PL_OFS_MSK: rdata_nxt[1:0] = msk_r;
            default: rdata_nxt = '0;
        endcase
    end
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            AVS_READDATA <= '0;
        end else if (AVS_READ && bus_r == p2pl_pkg::P2PL_IDLE) begin
            AVS_READDATA <= rdata_nxt;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            pin_output_bits_r <= `P2PL_RST8;
            pin_direction_bits_r <= `P2PL_RST8;
            pin_edge_select_bits_r <= `P2PL_RST8;
            pin_irq_enable_bits_r <= `P2PL_RST8;
            pin_function_select_r <= `P2PL_RST8;
            msk_r <= '0;
        end else if (wr) begin
            unique case (AVS_ADDRESS)
                `P2PL_OFS_OUT: pin_output_bits_r <= AVS_WRITEDATA[7:0];
                `P2PL_OFS_DIR: pin_direction_bits_r <= AVS_WRITEDATA[7:0];
                `P2PL_OFS_IES: pin_edge_select_bits_r <= AVS_WRITEDATA[7:0];
                `P2PL_OFS_IE: pin_irq_enable_bits_r <= AVS_WRITEDATA[7:0];
                `P2PL_OFS_SEL: pin_function_select_r <= AVS_WRITEDATA[7:0];
                `P2PL_OFS_MSK: msk_r <= AVS_WRITEDATA[1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Pin interrupt flags
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            prev_in_r <= `P2PL_RST8;
        end else begin
            prev_in_r <= pin_input_bits_r;
        end
    end
    // R13: edge chosen by edge select bit.
    assign edge_hit = ((pin_edge_select_bits_r & prev_in_r & ~pin_input_bits_r)
        | (~pin_edge_select_bits_r & ~prev_in_r & pin_input_bits_r)) & `P2PL_BONDED;
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            pin_irq_flag_bits_r <= `P2PL_RST8;
        end else begin
            // R12: unbonded flags only change by write; edges win over the write.
            pin_irq_flag_bits_r <= (flag_wr ? AVS_WRITEDATA[7:0] : pin_irq_flag_bits_r) | edge_hit;
        end
    end
    // R13: request from flag and enable.
    assign PIN_IRQ_REQUEST = |(pin_irq_flag_bits_r & pin_irq_enable_bits_r);

    // ----------------------------------------
    // Block events: 0 = pin request rose, 1 = segment select changed
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            req_prev_r <= 1'b0;
            seg_prev_r <= 1'b0;
            evt_r <= '0;
        end else begin
            req_prev_r <= PIN_IRQ_REQUEST;
            seg_prev_r <= PORT_OR_SEGMENT_SELECT;
            evt_r <= (evt_r & ~((wr && AVS_ADDRESS == `P2PL_OFS_EVT) ? AVS_WRITEDATA[1:0] : 2'b00))
                | {PORT_OR_SEGMENT_SELECT != seg_prev_r,
                   PIN_IRQ_REQUEST && !req_prev_r};
        end
    end
    assign IRQ = |(evt_r & msk_r);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // R1: segment blocks drive.
    a_seg_blocks_oe: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R1
        PORT_OR_SEGMENT_SELECT |=> PAD_OE[1:0] == 2'b00)
        else $error("segment pins driven");

    // R1: port path kept.
    a_seg_port_on: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R1
        !PORT_OR_SEGMENT_SELECT && !pin_function_select_r[0]
        |=> PAD_OE[0] == $past(pin_direction_bits_r[0]))
        else $error("port path lost on bit 0");

    // R2: threshold gates inputs.
    a_seg_threshold: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R2
        LCD_MEMORY_EXTENT >= `P2PL_LCD_LIMIT |=> !TIMER_CH2_CAPTURE_IN_A && !SERIAL_UNIT_CLOCK_IN)
        else $error("segment select bad");

    // R3: bit 2 kept.
    a_analog_tie: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R3
        !pin_function_select_r[2] |=> PAD_OE[2] == $past(pin_direction_bits_r[2]))
        else $error("bit 2 port path lost");

    // R4: bit 3 released.
    a_svs_disconnect: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R4
        SUPERVISOR_LEVEL_FIELD == `P2PL_SVS_EXT |=> PAD_OE[3] == 1'b0)
        else $error("bit 3 not released");

    // R5: register direction.
    a_reg_dir: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R5
        !pin_function_select_r[5] |=> PAD_OE[5] == $past(pin_direction_bits_r[5]))
        else $error("register direction lost");

    // R6: timer output.
    a_timer_out: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R6
        pin_function_select_r[0] |=> PAD_OUT[0] == $past(TIMER_CH2_OUT_SIGNAL))
        else $error("timer output not on bit 0");

    // R6: capture input feed.
    a_capture_in: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R6
        1'b1 |=> TIMER_CH2_CAPTURE_IN_A
            == ($past(pin_input_bits_r[0]) && !$past(PORT_OR_SEGMENT_SELECT)))
        else $error("capture input wrong");

    // R7: serial clock path.
    a_sclk_path: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R7
        pin_function_select_r[1] && !PORT_OR_SEGMENT_SELECT
        |=> PAD_OE[1] == $past(SERIAL_CLOCK_DIR_FROM_MODULE)
            && PAD_OUT[1] == $past(SERIAL_UNIT_CLOCK_OUT))
        else $error("serial clock path wrong");

    // R8: slave enable pin.
    a_ste_in: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R8
        pin_function_select_r[2] |=> !PAD_OE[2] && !PAD_OUT[2])
        else $error("slave enable pin driven");

    // R8: slave enable feed.
    a_ste_feed: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R8
        1'b1 |=> SERIAL_SLAVE_TX_ENABLE == $past(pin_input_bits_r[2]))
        else $error("slave enable feed wrong");

    // R9: transmit pin.
    a_tx_out: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R9
        pin_function_select_r[4] |=> PAD_OE[4] && PAD_OUT[4] == $past(ASYNC_TX_DATA))
        else $error("tx pin wrong");

    // R10: receive pin.
    a_rx_in: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R10
        pin_function_select_r[5] |=> !PAD_OE[5])
        else $error("rx pin driven");

    // R10: receive data feed.
    a_rx_feed: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R10
        1'b1 |=> ASYNC_RX_DATA == $past(pin_input_bits_r[5]))
        else $error("receive feed wrong");

    // R11: unbonded module output.
    a_unbonded_out: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R11
        1'b1 |=> (pad_r.out[7:6] & $past(pin_function_select_r[7:6])) == 2'b00)
        else $error("unbonded module output not low");

    // R12: unbonded flags soft.
    a_unbonded_flag: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R12
        !flag_wr |=> pin_irq_flag_bits_r[7:6] == $past(pin_irq_flag_bits_r[7:6]))
        else $error("unbonded flag moved");

    // R13: edge sets flag.
    a_edge_flag: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R13
        edge_hit != 8'h00 |=> (pin_irq_flag_bits_r & $past(edge_hit)) == $past(edge_hit))
        else $error("edge lost against write");

    // R14: input register follows.
    a_input_sync: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R14
        ##2 pin_input_bits_r[5:0] == $past(PAD_IN, 2))
        else $error("input register stale");

    // ----------------------------------------
    // Bus and event checks
    // ----------------------------------------
    // Read data carries the register in the low byte only.
    a_read_sel: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        AVS_READ && bus_r == p2pl_pkg::P2PL_IDLE && AVS_ADDRESS == `P2PL_OFS_SEL
        |=> AVS_READDATA == {24'h000000, $past(pin_function_select_r)})
        else $error("read data wrong");

    // The answer follows one wait cycle after the request.
    a_bus_answer: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (AVS_READ || AVS_WRITE) && bus_r == p2pl_pkg::P2PL_IDLE |=> !AVS_WAITREQUEST)
        else $error("answer late");

    // A set segment select event stays until a one is written to it.
    a_event_sticky: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        evt_r[1] && !(wr && AVS_ADDRESS == `P2PL_OFS_EVT && AVS_WRITEDATA[1])
        |=> evt_r[1])
        else $error("event bit lost");

    // ----------------------------------------
    // Cover points
    // ----------------------------------------
    c_seg_mode: cover property (@(posedge REF_CLK) PORT_OR_SEGMENT_SELECT);
    c_pin_irq: cover property (@(posedge REF_CLK) PIN_IRQ_REQUEST && IRQ);
    c_module_mode: cover property (@(posedge REF_CLK) pin_function_select_r[1] && PAD_OE[1]);
    c_soft_flag: cover property (@(posedge REF_CLK) pin_irq_flag_bits_r[7:6] != 2'b00);
    c_bus_answer: cover property (@(posedge REF_CLK) AVS_READ && !AVS_WAITREQUEST);
endmodule // p2pl_top

/* File: p2pl_pads.sv */
// Pad and board model seen by the port 2 pins.
module p2pl_pads (
    input wire logic [5:0] pad_out,
    input wire logic [5:0] pad_oe,
    input wire logic [5:0] ext_drive,
    output logic [5:0] pad_level
);
    // --------------------------------
    // Wire resolution
    // --------------------------------
    // The pads have no pull, so the board level shows wherever the block lets go.
    // In the routing loop the bench sets that level at random, so a stale value seldom passes by luck.
    always_comb pad_level = (pad_oe & pad_out) | (~pad_oe & ext_drive);
endmodule // p2pl_pads

/* File: p2pl_top_test.sv */
// Self-checking testbench for the port 2 pin function logic.
module p2pl_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, rd, wr, wreq, tmr, sdir, sclk, tx, seg, svs, cap, sclk_in, ste, rxd;
    logic pirq, irq;
    logic [3:0] adr, lvl;
    logic [31:0] wdat, rdat, q, r;
    logic [5:0] pout, poe, ext, pin, lv, g;
    logic [7:0] lcd, sel, dir, out;
    logic [11:0] e;
    logic [3:0] be;
    logic [31:0] seed = 32'hd400;
    int mismatches, checked;

    p2pl_top u_p2pl_top (
        .REF_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .PAD_IN(pin), .PAD_OUT(pout), .PAD_OE(poe),
        .LCD_MEMORY_EXTENT(lcd), .SUPERVISOR_LEVEL_FIELD(lvl),
        .PORT_OR_SEGMENT_SELECT(seg), .SUPERVISOR_EXT_INPUT_EN(svs),
        .TIMER_CH2_OUT_SIGNAL(tmr), .TIMER_CH2_CAPTURE_IN_A(cap),
        .SERIAL_CLOCK_DIR_FROM_MODULE(sdir), .SERIAL_UNIT_CLOCK_OUT(sclk),
        .SERIAL_UNIT_CLOCK_IN(sclk_in), .SERIAL_SLAVE_TX_ENABLE(ste),
        .ASYNC_TX_DATA(tx), .ASYNC_RX_DATA(rxd), .PIN_IRQ_REQUEST(pirq), .IRQ(irq));
    p2pl_pads u_p2pl_pads (.pad_out(pout), .pad_oe(poe), .ext_drive(ext), .pad_level(pin));

    // --------------------------------
    // Helpers
    // --------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [5:0] gate();
        return {2'b00, lvl == 4'hf, 1'b0, {2{lcd >= 8'he0}}};
    endfunction
    // Expected {drive enable, driven data}; data counts only where the pad is driven.
    function automatic logic [11:0] exp_pad();
        logic [5:0] oe;
        oe = ((dir[5:0] & ~sel[5:0]) | ({2'b01, dir[3], 1'b0, sdir, dir[0]} & sel[5:0]));
        oe = oe & ~gate();
        return {oe, ((out[5:0] & ~sel[5:0]) | ({1'b0, tx, 2'b00, sclk, tmr} & sel[5:0])) & oe};
    endfunction
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
        checked++;
        if (s !== x) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, x, s);
        end
    endtask
    // Ends on a falling edge so combinational outputs have settled for the caller.
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wdat <= {24'h0, d};
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wreq !== 1'b0 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n >= 50) begin
            mismatches++;
            $display("mismatch waitrequest expected 0 seen %b", wreq);
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] x, input string nm);
        bus(1'b0, a, 8'h00);
        chk(nm, {24'h0, x}, q);
    endtask
    task automatic pad_to(input logic [5:0] v);
        @(posedge clk);
        ext <= v;
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic conclude();
        $display("counts: %0d checked, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // --------------------------------
    // Tests
    // --------------------------------
    initial begin
        {rst_n, rd, wr, tmr, sdir, sclk, tx, adr, lvl, wdat, ext, lcd, sel, dir, out} = '0;
        be = 4'h1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 1; a < 10; a++) rdchk(a[3:0], 8'h00, "reset value");
        @(posedge clk);
        be <= 4'h0;
        bus(1'b1, 4'h1, 8'h55);
        @(posedge clk);
        be <= 4'h1;
        rdchk(4'h1, 8'h00, "byte lane ignored");
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            sel = r[7:0];
            dir = r[15:8];
            out = r[23:16];
            bus(1'b1, 4'h1, out);
            bus(1'b1, 4'h2, dir);
            bus(1'b1, 4'h6, sel);
            r = rnd();
            @(posedge clk);
            {tmr, sdir, sclk, tx, ext} <= r[9:0];
            lcd <= (i < 2) ? (i ? 8'he0 : 8'hdf) : (i % 2 ? r[17:10] : r[17:10] % 8'he0);
            lvl <= (i == 2) ? 4'hf : r[21:18];
            repeat (5) @(posedge clk);
            @(negedge clk);
            e = exp_pad();
            g = gate();
            lv = e[5:0] | (~e[11:6] & ext);
            chk("segment select", lcd >= 8'he0, seg);
            chk("supervisor input", lvl == 4'hf, svs);
            chk("pad drive", e, {poe, pout & poe});
            if (sel[0]) chk("capture in", lv[0] & ~g[0], cap);
            if (sel[1]) chk("serial clock in", lv[1] & ~g[1], sclk_in);
            if (sel[2]) chk("slave enable", lv[2], ste);
            if (sel[5]) chk("receive data", lv[5], rxd);
            bus(1'b0, 4'h0, 8'h00);
            chk("input bits", lv & ~g, q[5:0] & ~g);
        end
        $display("test pin routing done");
        sel = '0;
        bus(1'b1, 4'h6, 8'h00);
        bus(1'b1, 4'h2, 8'h00);
        lcd <= 8'h00;
        lvl <= 4'h0;
        pad_to(6'h00);
        bus(1'b1, 4'h3, 8'h00);
        bus(1'b1, 4'h7, 8'hff);
        bus(1'b1, 4'h4, 8'h00);
        bus(1'b1, 4'h5, 8'h04);
        bus(1'b1, 4'h8, 8'h01);
        chk("request idle", 1'b0, pirq);
        chk("irq idle", 1'b0, irq);
        pad_to(6'h04);
        rdchk(4'h3, 8'h04, "flags rising");
        chk("request", 1'b1, pirq);
        chk("irq raised", 1'b1, irq);
        bus(1'b1, 4'h8, 8'h00);
        chk("irq masked", 1'b0, irq);
        bus(1'b1, 4'h8, 8'h01);
        chk("irq unmasked", 1'b1, irq);
        bus(1'b1, 4'h7, 8'h01);
        chk("irq cleared", 1'b0, irq);
        bus(1'b1, 4'h3, 8'h00);
        bus(1'b1, 4'h4, 8'h04);
        pad_to(6'h00);
        rdchk(4'h3, 8'h04, "flags falling");
        bus(1'b1, 4'h3, 8'h00);
        pad_to(6'h04);
        rdchk(4'h3, 8'h00, "flags wrong edge");
        bus(1'b1, 4'h5, 8'hc0);
        bus(1'b1, 4'h3, 8'hc0);
        rdchk(4'h3, 8'hc0, "soft flags");
        chk("soft request", 1'b1, pirq);
        bus(1'b1, 4'h3, 8'h00);
        chk("soft cleared", 1'b0, pirq);
        bus(1'b1, 4'h7, 8'hff);
        @(posedge clk);
        lcd <= 8'he0;
        repeat (4) @(posedge clk);
        rdchk(4'h7, 8'h02, "segment event");
        bus(1'b1, 4'h8, 8'h02);
        chk("segment irq", 1'b1, irq);
        $display("test interrupts done");
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        conclude();
    end
endmodule // p2pl_top_test
